// *** logic/bcd_pkg.sv ***
package bcd_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] CAP_HEAD_OFFSET = 12'h034;
  localparam logic [11:0] BRIDGE_CTRL_OFFSET = 12'h03C;
  localparam logic [31:0] CAP_HEAD_RESET = 32'h00000080;
  localparam logic [7:0] CAP_HEAD_VALUE = 8'h80;
  localparam logic [31:0] BRIDGE_CTRL_RESET = 32'h000000FF;

  // ****************************************
  // Field positions in bridge control
  // ****************************************
  localparam int TIMER_SEL_BIT = 25;
  localparam int DISCARD_STAT_BIT = 26;
  localparam int DISCARD_MSG_EN_BIT = 27;
  localparam logic [7:0] INT_LINE_RESET = 8'hFF;

  // ****************************************
  // Discard timer counts in PCI clocks
  // ****************************************
  localparam logic [15:0] TIMER_LONG_COUNT = 16'h8000;
  localparam logic [15:0] TIMER_SHORT_COUNT = 16'h0400;

  // Severity codes of the upstream error message
  typedef enum logic [1:0] {
    BCD_MSG_NONFATAL = 2'h1,
    BCD_MSG_FATAL = 2'h2
  } bcd_msg_t;

  // Configuration access carried as one group
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bcd_cfg_req_t;

endpackage

// *** logic/bcd_discard_timer.sv ***
`timescale 1ns/1ps
module bcd_discard_timer (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic pci_clk_tick_in,
  input wire logic start_in,
  input wire logic repeat_in,
  input wire logic short_sel_in,
  output logic expire_out
);

  logic [15:0] count;
  logic running;
  logic [15:0] limit;

  // Limit picked by the select bit, sampled each cycle
  assign limit = short_sel_in ? bcd_pkg::TIMER_SHORT_COUNT : bcd_pkg::TIMER_LONG_COUNT; // [R8]

  // Counter of PCI clocks while a completion waits at the queue head
  always_ff @(posedge clock_in) begin
    if (srst_in || repeat_in || expire_out) begin
      running <= 1'b0; // [R9]
      count <= 16'h0000;
    end else if (start_in) begin
      running <= 1'b1;
      count <= 16'h0000;
    end else if (running && pci_clk_tick_in) begin
      count <= count + 16'h0001;
    end
  end

  // Expiry pulse when the master failed to repeat in time
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      expire_out <= 1'b0;
    end else begin
      expire_out <= running && !repeat_in && !expire_out && pci_clk_tick_in &&
                    (count + 16'h0001 >= limit); // [R8] [R9]
    end
  end

endmodule

// *** logic/bcd_bridge_regs.sv ***
`timescale 1ns/1ps
// Operation
// (R1) Capability pointer low byte reads fixed 0x80, read only.
// (R2) Discard enable and status act only in conventional PCI mode.
// (R3) Enable set and timer expiry discard send an error message upstream.
// (R4) Message is nonfatal by default; fatal only when advanced reporting exists.
// (R5) Enable clear sends no message, unless unmasked advanced reporting asks.
// (R6) Status flag sets when the timer expires and a completion is dropped.
// (R7) Status flag resets to 0 and clears on software write of one.
// (R8) Timer counts 2^15 PCI clocks with select 0, 2^10 with select 1.
// (R9) Master must repeat before expiry, else transaction deleted and flagged.
// (R10) Reserved bits read zero and ignore writes.
module bcd_bridge_regs #(
  parameter bit AER_PRESENT = 1'b1
) (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire bcd_pkg::bcd_cfg_req_t cfg_req_in,
  input wire logic pcix_mode_in,
  input wire logic pci_clk_tick_in,
  input wire logic dt_at_head_in,
  input wire logic dt_repeat_in,
  input wire logic aer_fatal_sel_in,
  input wire logic aer_discard_mask_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_ack_out,
  output logic dt_discard_out,
  output logic err_msg_valid_out,
  output bcd_pkg::bcd_msg_t err_msg_type_out,
  output logic secondary_timer_select_out
);

  // ****************************************
  // Decoding helpers
  // ****************************************

  // Full offset compare; a partial decode would alias other header words
  function automatic logic hit_offset(input logic [11:0] addr, input logic [11:0] offset);
    return addr == offset;
  endfunction

  // Write strobe for one byte lane of the control word
  function automatic logic lane_write(input bcd_pkg::bcd_cfg_req_t req, input int lane);
    return req.wr && hit_offset(req.addr, bcd_pkg::BRIDGE_CTRL_OFFSET) && req.be[lane];
  endfunction

  // ****************************************
  // Register state
  // ****************************************
  logic discard_error_msg_enable;
  logic discard_status;
  logic secondary_timer_select;
  logic [7:0] int_line;

  // Decoded request and timer events
  logic expire;
  logic pci_mode;
  logic hit_cap;
  logic hit_ctrl;
  logic wr_lane3;
  logic wr_lane0;
  logic status_clear;
  logic timer_start;
  logic discard_now;
  logic msg_wanted;
  logic [31:0] next_rdata;

  // ****************************************
  // Request decoding
  // ****************************************

  // PCI-X mode turns the discard machinery off entirely
  assign pci_mode = !pcix_mode_in; // [R2]

  // Address hits for the read mux; the write path decodes its own hit through lane_write
  assign hit_cap = hit_offset(cfg_req_in.addr, bcd_pkg::CAP_HEAD_OFFSET);
  assign hit_ctrl = hit_offset(cfg_req_in.addr, bcd_pkg::BRIDGE_CTRL_OFFSET);

  // Lane 3 carries the discard fields, lane 0 the interrupt line
  assign wr_lane3 = lane_write(cfg_req_in, 3);
  assign wr_lane0 = lane_write(cfg_req_in, 0);

  // Write one to clear; a zero in the status bit leaves it alone
  assign status_clear = wr_lane3 && cfg_req_in.wdata[bcd_pkg::DISCARD_STAT_BIT]; // [R7]

  // ****************************************
  // Discard timer
  // ****************************************

  // A completion reaching the head only arms the timer in conventional mode
  assign timer_start = dt_at_head_in && pci_mode; // [R2]

  // Select is read every cycle, so a change moves the limit of a running count
  // Repeat from the master stops the count; only a new head arrival restarts it
  bcd_discard_timer u_timer (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .pci_clk_tick_in(pci_clk_tick_in),
    .start_in(timer_start),
    .repeat_in(dt_repeat_in),
    .short_sel_in(secondary_timer_select),
    .expire_out(expire)
  );

  // Expiry only counts while the secondary side is in conventional mode
  assign discard_now = expire && pci_mode; // [R2] [R9]

  // Enable bit or, with advanced reporting, a clear mask asks for a message
  assign msg_wanted = discard_error_msg_enable ||
                      (AER_PRESENT && !aer_discard_mask_in); // [R3] [R5]

  // ****************************************
  // Control fields
  // ****************************************

  // Error message enable, byte lane 3
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      discard_error_msg_enable <= 1'b0;
    end else if (wr_lane3) begin
      discard_error_msg_enable <= cfg_req_in.wdata[bcd_pkg::DISCARD_MSG_EN_BIT]; // [R3]
    end
  end

  // Timer length select, byte lane 3
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      secondary_timer_select <= 1'b0;
    end else if (wr_lane3) begin
      secondary_timer_select <= cfg_req_in.wdata[bcd_pkg::TIMER_SEL_BIT]; // [R8]
    end
  end

  // Interrupt line byte, plain storage for software
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      int_line <= bcd_pkg::INT_LINE_RESET;
    end else if (wr_lane0) begin
      int_line <= cfg_req_in.wdata[7:0];
    end
  end

  // Sticky status; a fresh expiry beats a same-cycle clear
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      discard_status <= 1'b0; // [R7]
    end else if (discard_now) begin
      discard_status <= 1'b1; // [R6] [R9]
    end else if (status_clear) begin
      discard_status <= 1'b0; // [R7]
    end
  end

  // ****************************************
  // Upstream error message
  // ****************************************

  // Discard pulse, one cycle per deleted transaction
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      dt_discard_out <= 1'b0;
    end else begin
      dt_discard_out <= discard_now; // [R9]
    end
  end

  // Message pulse, in the same cycle as the discard pulse
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      err_msg_valid_out <= 1'b0;
    end else begin
      err_msg_valid_out <= discard_now && msg_wanted; // [R3] [R5]
    end
  end

  // Severity; without advanced reporting the fatal select is ignored
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      err_msg_type_out <= bcd_pkg::BCD_MSG_NONFATAL;
    end else if (AER_PRESENT && aer_fatal_sel_in) begin
      err_msg_type_out <= bcd_pkg::BCD_MSG_FATAL; // [R4]
    end else begin
      err_msg_type_out <= bcd_pkg::BCD_MSG_NONFATAL; // [R4]
    end
  end

  // ****************************************
  // Read path
  // ****************************************

  // Read mux; reserved, unmapped and left-out bits read zero
  always_comb begin
    next_rdata = 32'h00000000;
    if (hit_cap) begin
      next_rdata[7:0] = bcd_pkg::CAP_HEAD_VALUE; // [R1] [R10]
    end else if (hit_ctrl) begin
      next_rdata[7:0] = int_line;
      next_rdata[bcd_pkg::DISCARD_MSG_EN_BIT] = discard_error_msg_enable; // [R10]
      next_rdata[bcd_pkg::DISCARD_STAT_BIT] = discard_status; // [R7]
      next_rdata[bcd_pkg::TIMER_SEL_BIT] = secondary_timer_select;
    end
  end

  // Read data, zero outside a read so stale words never show
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cfg_rdata_out <= 32'h00000000;
    end else begin
      cfg_rdata_out <= cfg_req_in.rd ? next_rdata : 32'h00000000;
    end
  end

  // Acknowledge one cycle after any access, refused writes included
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      cfg_ack_out <= 1'b0;
    end else begin
      cfg_ack_out <= cfg_req_in.rd || cfg_req_in.wr;
    end
  end

  // Registered copy of the select for logic on the secondary side
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      secondary_timer_select_out <= 1'b0;
    end else begin
      secondary_timer_select_out <= secondary_timer_select; // [R8]
    end
  end

endmodule

// *** tb/bcd_regs_checker.sv ***
`timescale 1ns/1ps
// ****
// Port checks
// ****
module bcd_regs_checker (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire bcd_pkg::bcd_cfg_req_t cfg_req_in,
  input wire logic pcix_mode_in,
  input wire logic aer_fatal_sel_in,
  input wire logic [31:0] cfg_rdata_out,
  input wire logic cfg_ack_out,
  input wire logic dt_discard_out,
  input wire logic err_msg_valid_out,
  input wire bcd_pkg::bcd_msg_t err_msg_type_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  ack_follows_a: assert property ((cfg_req_in.rd || cfg_req_in.wr) |=> cfg_ack_out)
    else $error("ack missing");
  ack_cause_a: assert property (cfg_ack_out |-> $past(cfg_req_in.rd || cfg_req_in.wr))
    else $error("ack without request");
  idle_zero_a: assert property (!cfg_ack_out |-> cfg_rdata_out == 32'h0)
    else $error("read data outside ack");
  cap_fixed_a: assert property (cfg_req_in.rd && cfg_req_in.addr == bcd_pkg::CAP_HEAD_OFFSET
    |=> cfg_rdata_out == bcd_pkg::CAP_HEAD_RESET) else $error("pointer value wrong");
  msg_cause_a: assert property (err_msg_valid_out |-> dt_discard_out)
    else $error("message without discard");
  pcix_quiet_a: assert property (pcix_mode_in && $past(pcix_mode_in) |-> !dt_discard_out)
    else $error("discard in other mode");
  nonfatal_dflt_a: assert property (err_msg_valid_out && !aer_fatal_sel_in
    && !$past(aer_fatal_sel_in) |-> err_msg_type_out == bcd_pkg::BCD_MSG_NONFATAL)
    else $error("severity wrong");
  discard_once_a: assert property (dt_discard_out |=> !dt_discard_out)
    else $error("discard held");
endmodule
bind bcd_bridge_regs bcd_regs_checker u_checker (.clock_in(clock_in), .srst_in(srst_in),
  .cfg_req_in(cfg_req_in), .pcix_mode_in(pcix_mode_in), .aer_fatal_sel_in(aer_fatal_sel_in),
  .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out), .dt_discard_out(dt_discard_out),
  .err_msg_valid_out(err_msg_valid_out), .err_msg_type_out(err_msg_type_out));

// *** tb/bcd_host_model.sv ***
`timescale 1ns/1ps
// Config host, one access per call
module bcd_host_model (
  input wire logic clock_in,
  output bcd_pkg::bcd_cfg_req_t cfg_req_out
);
  initial cfg_req_out = '0;
  // Release inverts data so stale values cannot pass
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge clock_in);
    cfg_req_out = '{!w, w, a, 4'hF, d};
    @(negedge clock_in);
    cfg_req_out = '{1'b0, 1'b0, ~a, 4'h0, ~d};
  endtask
endmodule

// *** tb/bcd_bridge_regs_test.sv ***
`timescale 1ns/1ps
module bcd_bridge_regs_test;
  logic clock_in = 0, srst_in = 1, pcix = 0, tick = 1, head = 0, rep = 0, fsel = 0, mask = 1;
  logic ack, disc, msg, sel;
  logic slow = 0;
  localparam int SHORT_N = bcd_pkg::TIMER_SHORT_COUNT;
  localparam int LONG_N = bcd_pkg::TIMER_LONG_COUNT;
  logic [31:0] rdata;
  bcd_pkg::bcd_cfg_req_t req;
  bcd_pkg::bcd_msg_t mtype;
  int err_count = 0, n_compared = 0;
  always #4 clock_in = ~clock_in;
  bcd_host_model u_host (.clock_in(clock_in), .cfg_req_out(req));
  bcd_bridge_regs u_dut (.clock_in(clock_in), .srst_in(srst_in), .cfg_req_in(req),
    .pcix_mode_in(pcix), .pci_clk_tick_in(tick), .dt_at_head_in(head), .dt_repeat_in(rep),
    .aer_fatal_sel_in(fsel), .aer_discard_mask_in(mask), .cfg_rdata_out(rdata),
    .cfg_ack_out(ack), .dt_discard_out(disc), .err_msg_valid_out(msg),
    .err_msg_type_out(mtype), .secondary_timer_select_out(sel));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    u_host.access(1'b0, a, 32'h0);
    check("ack", {31'h0, ack}, 32'h1);
    check("rdata", rdata, exp);
  endtask
  // One falling edge; in slow mode the PCI tick comes every other cycle
  task automatic step;
    @(negedge clock_in);
    tick = slow ? !tick : 1'b1;
  endtask
  // Levels {pcix, fatal, mask, repeat}; result {discard, message, fatal}; n ticks to expiry
  task automatic run(input logic [3:0] lv, input logic [2:0] exp, input int n);
    logic [2:0] seen;
    int at;
    seen = 3'h0;
    at = 0;
    @(negedge clock_in);
    {pcix, fsel, mask} = lv[3:1];
    tick = !slow;
    step;
    head = 1;
    step;
    head = 0;
    rep = lv[0];
    step;
    rep = 0;
    for (int i = 1; i <= (n << slow) + 64; i++) begin
      step;
      if (disc === 1'b1 && at == 0) begin
        seen = {1'b1, msg, mtype === bcd_pkg::BCD_MSG_FATAL};
        at = i;
      end
    end
    check("discard", {29'h0, seen}, {29'h0, exp});
    if (exp[2]) check("expiry cycle", at, n << slow);
  endtask
  task automatic end_of_test;
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Timer uses the short count in every run but the last, which uses the long count
  initial begin
    repeat (6) @(negedge clock_in);
    srst_in = 0;
    rd(12'h034, 32'h00000080);
    rd(12'h03C, 32'h000000FF);
    u_host.access(1'b1, 12'h034, 32'hFFFFFFFF);
    rd(12'h034, 32'h00000080);
    u_host.access(1'b1, 12'h03C, 32'hFFFFFFFF);
    rd(12'h03C, 32'h0A0000FF);
    check("select", {31'h0, sel}, 32'h1);
    run(4'b0010, 3'b110, SHORT_N);
    rd(12'h03C, 32'h0E0000FF);
    u_host.access(1'b1, 12'h03C, 32'h0E0000FF);
    rd(12'h03C, 32'h0A0000FF);
    run(4'b0011, 3'b000, SHORT_N);
    run(4'b1010, 3'b000, SHORT_N);
    u_host.access(1'b1, 12'h03C, 32'h020000FF);
    run(4'b0010, 3'b100, SHORT_N);
    run(4'b0100, 3'b111, SHORT_N);
    // Tick every other cycle: the count must follow PCI clocks, not core clocks
    slow = 1;
    run(4'b0010, 3'b100, SHORT_N);
    slow = 0;
    // Select back to 0 for the long count; status stays set from the runs above
    u_host.access(1'b1, 12'h03C, 32'h08000000);
    rd(12'h03C, 32'h0C000000);
    check("select", {31'h0, sel}, 32'h0);
    run(4'b0010, 3'b110, LONG_N);
    end_of_test;
  end
  // Hang guard, about twice the expected run
  initial begin
    #700000;
    err_count++;
    end_of_test;
  end
endmodule
